// *** design/trig_mux.sv ***
/*
  Trigger-source selector for four sample sequencers with its
  select register on classic Wishbone.
  Assumes event inputs from peripherals on other clocks or pins are
  levels or pulses of at least three system clocks; all pass a
  two-stage synchroniser. Timer events arrive only when that timer
  has enabled its output trigger.
*/
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Bits 11:8 pick sequencer 2 start event, reset 0x0.
// [RULE2] Bits 7:4 pick sequencer 1 start event, reset 0x0.
// [RULE3] Bits 3:0 pick sequencer 0 start event, reset 0x0.
// [RULE4] Codes: 0 software, 1 comparator 0, 4 external pin, F continuous.
// [RULE5] Code 5 starts on timer event, which needs timer output trigger enabled.
// [RULE6] Code 6 starts on PWM generator 0 trigger output.
// [RULE7] Code 7 starts on PWM generator 1 trigger output.
// [RULE8] Reserved codes produce no start event.
// [RULE9] Bits 15:12 pick sequencer 3 start event, same code table.
// [RULE10] Register read/write at offset 0x014, reset zero.
module trig_mux (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [11:0] WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        SW_TRIGGER,
  input  wire logic        COMPARATOR_EVENT,
  input  wire logic        EXT_PIN_EVENT,
  input  wire logic        TIMER_EVENT,
  input  wire logic        PWM_GEN0_TRIGGER,
  input  wire logic        PWM_GEN1_TRIGGER,
  output logic      [3:0]  SEQ_START
);
  trig_mux_pkg::wb_req_t      req;
  trig_mux_pkg::trig_events_t events;
  logic [31:0] sequencer_trigger_select;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        take;
  logic        hit;
  logic        wr_en;
  logic        comp_meta;
  logic        comp_sync;
  logic        pin_meta;
  logic        pin_sync;
  logic        timer_meta;
  logic        timer_sync;
  logic        pwm0_meta;
  logic        pwm0_sync;
  logic        pwm1_meta;
  logic        pwm1_sync;
  logic        next_comp_meta;
  logic        next_comp_sync;
  logic        next_pin_meta;
  logic        next_pin_sync;
  logic        next_timer_meta;
  logic        next_timer_sync;
  logic        next_pwm0_meta;
  logic        next_pwm0_sync;
  logic        next_pwm1_meta;
  logic        next_pwm1_sync;
  logic [3:0]  seq0_trigger_code;
  logic [3:0]  seq1_trigger_code;
  logic [3:0]  seq2_trigger_code;
  logic [3:0]  seq3_trigger_code;
  logic [3:0]  next_seq0_code;
  logic [3:0]  next_seq1_code;
  logic [3:0]  next_seq2_code;
  logic [3:0]  next_seq3_code;

  assign req = '{cyc: WB_CYC_I,
                 stb: WB_STB_I,
                 we:  WB_WE_I,
                 sel: WB_SEL_I,
                 adr: WB_ADR_I,
                 dat: WB_DAT_I};

  // Two stages per asynchronous source; only the second stage feeds the selectors
  always_comb begin
    next_comp_meta  = COMPARATOR_EVENT;
    next_comp_sync  = comp_meta;
    next_pin_meta   = EXT_PIN_EVENT;
    next_pin_sync   = pin_meta;
    next_timer_meta = TIMER_EVENT;
    next_timer_sync = timer_meta;
    next_pwm0_meta  = PWM_GEN0_TRIGGER;
    next_pwm0_sync  = pwm0_meta;
    next_pwm1_meta  = PWM_GEN1_TRIGGER;
    next_pwm1_sync  = pwm1_meta;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      comp_meta  <= 1'b0;
      comp_sync  <= 1'b0;
      pin_meta   <= 1'b0;
      pin_sync   <= 1'b0;
      timer_meta <= 1'b0;
      timer_sync <= 1'b0;
      pwm0_meta  <= 1'b0;
      pwm0_sync  <= 1'b0;
      pwm1_meta  <= 1'b0;
      pwm1_sync  <= 1'b0;
    end else begin
      comp_meta  <= next_comp_meta;
      comp_sync  <= next_comp_sync;
      pin_meta   <= next_pin_meta;
      pin_sync   <= next_pin_sync;
      timer_meta <= next_timer_meta;
      timer_sync <= next_timer_sync;
      pwm0_meta  <= next_pwm0_meta;
      pwm0_sync  <= next_pwm0_sync;
      pwm1_meta  <= next_pwm1_meta;
      pwm1_sync  <= next_pwm1_sync;
    end
  end

  // Software trigger comes from logic on this clock and needs no synchroniser
  always_comb begin
    events.software   = SW_TRIGGER;
    events.comparator = comp_sync;
    events.ext_pin    = pin_sync;
    events.timer      = timer_sync; // RULE5
    events.pwm_gen0   = pwm0_sync;  // RULE6
    events.pwm_gen1   = pwm1_sync;  // RULE7
  end

  // Single-cycle ack; ack drops for one cycle so a held strobe is not double acked
  always_comb begin
    take = req.cyc && req.stb && !WB_ACK_O;
    if (req.adr[11:2] == trig_mux_pkg::OFS_TRIG_SEL[11:2]) begin
      hit = 1'b1; // RULE10
    end else begin
      hit = 1'b0;
    end
    wr_en = take && hit && req.we;
  end

  // Lane 0 holds sequencers 0 and 1, lane 1 sequencers 2 and 3; upper lanes are reserved
  always_comb begin
    next_seq0_code = seq0_trigger_code;
    next_seq1_code = seq1_trigger_code;
    next_seq2_code = seq2_trigger_code;
    next_seq3_code = seq3_trigger_code;
    if (wr_en && req.sel[0]) begin
      next_seq0_code = req.dat[trig_mux_pkg::SEQ0_LSB +: trig_mux_pkg::CODE_W]; // RULE3
      next_seq1_code = req.dat[trig_mux_pkg::SEQ1_LSB +: trig_mux_pkg::CODE_W]; // RULE2
    end
    if (wr_en && req.sel[1]) begin
      next_seq2_code = req.dat[trig_mux_pkg::SEQ2_LSB +: trig_mux_pkg::CODE_W]; // RULE1
      next_seq3_code = req.dat[trig_mux_pkg::SEQ3_LSB +: trig_mux_pkg::CODE_W]; // RULE9
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      seq0_trigger_code <= trig_mux_pkg::TRIG_SEL_RESET[trig_mux_pkg::SEQ0_LSB +: trig_mux_pkg::CODE_W]; // RULE3
      seq1_trigger_code <= trig_mux_pkg::TRIG_SEL_RESET[trig_mux_pkg::SEQ1_LSB +: trig_mux_pkg::CODE_W]; // RULE2
      seq2_trigger_code <= trig_mux_pkg::TRIG_SEL_RESET[trig_mux_pkg::SEQ2_LSB +: trig_mux_pkg::CODE_W]; // RULE1
      seq3_trigger_code <= trig_mux_pkg::TRIG_SEL_RESET[trig_mux_pkg::SEQ3_LSB +: trig_mux_pkg::CODE_W]; // RULE9
    end else begin
      seq0_trigger_code <= next_seq0_code;
      seq1_trigger_code <= next_seq1_code;
      seq2_trigger_code <= next_seq2_code;
      seq3_trigger_code <= next_seq3_code;
    end
  end

  // Reserved upper half is never stored, so it reads zero and writes to it drop
  always_comb begin
    sequencer_trigger_select = '0;
    sequencer_trigger_select[trig_mux_pkg::SEQ0_LSB +: trig_mux_pkg::CODE_W] = seq0_trigger_code;
    sequencer_trigger_select[trig_mux_pkg::SEQ1_LSB +: trig_mux_pkg::CODE_W] = seq1_trigger_code;
    sequencer_trigger_select[trig_mux_pkg::SEQ2_LSB +: trig_mux_pkg::CODE_W] = seq2_trigger_code;
    sequencer_trigger_select[trig_mux_pkg::SEQ3_LSB +: trig_mux_pkg::CODE_W] = seq3_trigger_code;
  end

  always_comb begin
    next_ack = take;
    if (take && hit) begin
      next_dat = sequencer_trigger_select; // RULE10
    end else begin
      next_dat = trig_mux_pkg::UNMAPPED_DATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= trig_mux_pkg::UNMAPPED_DATA;
    end else begin
      WB_ACK_O <= next_ack;
      WB_DAT_O <= next_dat;
    end
  end

  trig_select u_sel0 (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .code    (seq0_trigger_code),
    .events  (events),
    .start   (SEQ_START[0])
  );
  trig_select u_sel1 (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .code    (seq1_trigger_code),
    .events  (events),
    .start   (SEQ_START[1])
  );
  trig_select u_sel2 (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .code    (seq2_trigger_code),
    .events  (events),
    .start   (SEQ_START[2])
  );
  trig_select u_sel3 (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .code    (seq3_trigger_code),
    .events  (events),
    .start   (SEQ_START[3])
  );
endmodule : trig_mux

// *** design/trig_mux_pkg.sv ***
/*
  Package for the sequencer trigger-source selector: register offset,
  field positions, reset value and the code table of the select fields.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package trig_mux_pkg;
  localparam int          NUM_SEQ        = 4;
  localparam int          CODE_W         = 4;
  localparam logic [11:0] OFS_TRIG_SEL   = 12'h014;
  localparam logic [31:0] TRIG_SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] TRIG_SEL_MASK  = 32'h0000_ffff;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
  localparam int          SEQ0_LSB       = 0;
  localparam int          SEQ1_LSB       = 4;
  localparam int          SEQ2_LSB       = 8;
  localparam int          SEQ3_LSB       = 12;

  typedef enum logic [3:0] {
    SRC_SOFTWARE   = 4'h0,
    SRC_COMPARATOR = 4'h1,
    SRC_EXT_PIN    = 4'h4,
    SRC_TIMER      = 4'h5,
    SRC_PWM_GEN0   = 4'h6,
    SRC_PWM_GEN1   = 4'h7,
    SRC_ALWAYS     = 4'hf
  } trig_code_t;

  // Event levels on the system clock seen by every select field
  typedef struct packed {
    logic software;
    logic comparator;
    logic ext_pin;
    logic timer;
    logic pwm_gen0;
    logic pwm_gen1;
  } trig_events_t;

  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } wb_req_t;
endpackage : trig_mux_pkg

// *** design/trig_select.sv ***
/*
  One select field: maps a 4-bit code onto one start event.
  Assumes event inputs are already synchronous to the system clock.
*/
`timescale 1ns/1ps
module trig_select (
  input  wire logic                       SYS_CLK,
  input  wire logic                       RST_N,
  input  wire logic [3:0]                 code,
  input  wire trig_mux_pkg::trig_events_t events,
  output logic                            start
);
  logic next_start;

  always_comb begin
    case (code)
      trig_mux_pkg::SRC_SOFTWARE:   next_start = events.software;   // RULE4
      trig_mux_pkg::SRC_COMPARATOR: next_start = events.comparator; // RULE4
      trig_mux_pkg::SRC_EXT_PIN:    next_start = events.ext_pin;    // RULE4
      trig_mux_pkg::SRC_TIMER:      next_start = events.timer;      // RULE5
      trig_mux_pkg::SRC_PWM_GEN0:   next_start = events.pwm_gen0;   // RULE6
      trig_mux_pkg::SRC_PWM_GEN1:   next_start = events.pwm_gen1;   // RULE7
      trig_mux_pkg::SRC_ALWAYS:     next_start = 1'b1;              // RULE4
      default:                      next_start = 1'b0;              // RULE8
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      start <= 1'b0;
    end else begin
      start <= next_start;
    end
  end
endmodule : trig_select

// *** verif/tb_top.sv ***
/* Bench for trig_mux: Wishbone register traffic, random events.
   Assumes the bound checker judges the start outputs. */
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_n, cyc, we, toe;
  logic        sw = 1'b0;
  logic [3:0]  sel, start;
  logic [11:0] adr;
  logic [15:0] sh;
  logic [31:0] wdat, rdat, q[$];
  logic        ack;
  int          error_cnt = 0;
  int          cmp_count = 0;
  trig_mux_pkg::trig_events_t ev;
  trig_mux uut (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_SEL_I(sel),
    .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SW_TRIGGER(sw),
    .COMPARATOR_EVENT(ev.comparator), .EXT_PIN_EVENT(ev.ext_pin), .TIMER_EVENT(ev.timer),
    .PWM_GEN0_TRIGGER(ev.pwm_gen0), .PWM_GEN1_TRIGGER(ev.pwm_gen1), .SEQ_START(start));
  trig_src_model src (.SYS_CLK(clk), .timer_oe(toe), .ev(ev));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) sw <= 1'($urandom);
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    if (!w) q.push_back(a[11:2] == 10'h5 ? {16'h0, sh} : 32'h0);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    if (w && a[11:2] == 10'h5 && s[0]) sh[7:0] = d[7:0];
    if (w && a[11:2] == 10'h5 && s[1]) sh[15:8] = d[15:8];
    @(posedge clk);
  endtask : bus
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      cmp_count++;
      if (rdat !== q[0]) begin
        error_cnt++;
        $display("[ERR] read data exp %h got %h", q[0], rdat);
      end
      void'(q.pop_front());
    end
  end
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    #(5000 * 100);
    error_cnt++;
    test_done();
  end
  initial begin
    void'($urandom(32'h909559e6));
    rst_n = 1'b0;
    cyc = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 12'h000;
    wdat = 32'h0000_0000;
    toe = 1'b0;
    sh = 16'h0000;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, 12'h014, 0, 4'hf);
    bus(0, 12'h018, 0, 4'hf);
    $display("reset and map test done");
    for (int i = 0; i < 16; i++) begin
      toe <= ~i[1];
      bus(1, 12'h014, {16'hffff, {4{4'(i)}}}, 4'hf);
      repeat (40) @(posedge clk);
      if (i == 15 || i == 2 || i == 3 || i >= 8) begin
        cmp_count++;
        if (start !== (i == 15 ? 4'hf : 4'h0)) begin
          error_cnt++;
          $display("[ERR] seq start exp %h got %h", (i == 15 ? 4'hf : 4'h0), start);
        end
      end
      bus(0, 12'h014, 0, 4'hf);
    end
    $display("code table test done");
    repeat (20) begin
      bus(1, $urandom_range(1) ? 12'h014 : 12'h010, $urandom, 4'($urandom));
      bus(0, 12'h014, 0, 4'hf);
    end
    $display("random access test done");
    test_done();
  end
endmodule : tb_top
bind trig_mux trig_mux_checker chk (.*);

// *** verif/trig_mux_checker.sv ***
/* Port checker for trig_mux.
   Assumes a bind from tb_top and codes in byte lanes 0 and 1. */
`timescale 1ns/1ps
module trig_mux_checker (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        SW_TRIGGER,
  input wire logic        COMPARATOR_EVENT,
  input wire logic        EXT_PIN_EVENT,
  input wire logic        TIMER_EVENT,
  input wire logic        PWM_GEN0_TRIGGER,
  input wire logic        PWM_GEN1_TRIGGER,
  input wire logic [3:0]  SEQ_START
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  logic [15:0] r;
  logic [2:0]  age;
  wire         hit = WB_ADR_I[11:2] == 10'h5;
  wire  [4:0]  ev = {PWM_GEN1_TRIGGER, PWM_GEN0_TRIGGER, TIMER_EVENT, EXT_PIN_EVENT, COMPARATOR_EVENT};
  // Age gates the start check until the synchroniser has flushed a code change
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      r <= 16'h0;
      age <= 3'h0;
    end else if (WB_ACK_O && WB_WE_I && hit) begin
      if (WB_SEL_I[0]) r[7:0] <= WB_DAT_I[7:0];
      if (WB_SEL_I[1]) r[15:8] <= WB_DAT_I[15:8];
      age <= 3'h0;
    end else if (age != 3'h7) age <= age + 3'h1;
  end
  function automatic logic want(input logic [3:0] c, input logic s, input logic [4:0] e);
    case (c)
      4'h0: want = s;
      4'h1: want = e[0];
      4'h4: want = e[1];
      4'h5: want = e[2];
      4'h6: want = e[3];
      4'h7: want = e[4];
      4'hf: want = 1'b1;
      default: want = 1'b0;
    endcase
  endfunction : want
  sequence s_take; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  property p_ack; s_take |=> WB_ACK_O; endproperty
  property p_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  property p_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  property p_read; WB_ACK_O && !WB_WE_I && hit |-> WB_DAT_O == {16'h0, r}; endproperty
  property p_unmap; WB_ACK_O && !hit |-> WB_DAT_O == 32'h0; endproperty
  property p_high; WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0; endproperty
  property p_cause; WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I); endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  a_pulse: assert property (p_pulse) else $error("ack too long");
  a_idle: assert property (p_idle) else $error("data outside ack");
  a_read: assert property (p_read) else $error("read value");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_high: assert property (p_high) else $error("upper bits");
  a_cause: assert property (p_cause) else $error("ack unasked");
  for (genvar n = 0; n < 4; n++) begin : g_seq
    property p_start;
      age >= 3'h5 |-> SEQ_START[n] == want(r[4*n +: 4], $past(SW_TRIGGER), $past(ev, 3));
    endproperty
    a_start: assert property (p_start) else $error("start");
  end
endmodule : trig_mux_checker

// *** verif/trig_src_model.sv ***
/* Event sources: comparator, pin, timer, two PWM generators.
   Assumes the bench seeds the generator before the first edge. */
`timescale 1ns/1ps
module trig_src_model (
  input  wire logic                  SYS_CLK,
  input  wire logic                  timer_oe,
  output trig_mux_pkg::trig_events_t ev
);
  logic [4:0] lv = 5'h0;
  // Held four cycles so the two-stage synchroniser never misses a level
  always begin
    repeat (4) @(posedge SYS_CLK);
    lv <= 5'($urandom);
  end
  assign ev = '{software:   1'b0,
                comparator: lv[0],
                ext_pin:    lv[1],
                timer:      lv[2] & timer_oe,
                pwm_gen0:   lv[3],
                pwm_gen1:   lv[4]};
endmodule : trig_src_model
